// ---- eeff_top.sv ----
// Enabled flop trio with reset and set variants behind an AHB-Lite slave.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
module eeff_top #(
   parameter string RESET_TIMING = eeff_pkg::EEFF_TIMING_DEFAULT,
   parameter string SET_TIMING   = eeff_pkg::EEFF_TIMING_DEFAULT,
   parameter logic  PLAIN_INIT   = eeff_pkg::EEFF_INIT_PLAIN,
   parameter logic  RESET_INIT   = eeff_pkg::EEFF_INIT_RESET,
   parameter logic  SET_INIT     = eeff_pkg::EEFF_INIT_SET,
   parameter int    LOAD_COUNT_W = eeff_pkg::EEFF_LD_FIELD_W
) (
   input  wire logic        i_clock,
   input  wire logic        i_reset,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_data_in,
   input  wire logic        i_enable_in,
   input  wire logic        i_reset_low_in,
   input  wire logic        i_set_low_in,
   output logic             o_plain_q,
   output logic             o_reset_q,
   output logic             o_set_q
);
   import eeff_pkg::*;

   if (LOAD_COUNT_W < 1 || LOAD_COUNT_W > EEFF_LD_FIELD_W) begin : g_bad_width
      $error("LOAD_COUNT_W must lie between 1 and the field width.");
   end

   // Decoded options, shown to software.
   localparam bit RESET_ASYNC = eeff_is_async(RESET_TIMING);
   localparam bit SET_ASYNC   = eeff_is_async(SET_TIMING);

   // Bus phase tracking.
   logic                   addr_phase;
   logic                   wr_pend_reg;
   logic [EEFF_ADDR_W-1:0] wr_addr_reg;
   logic                   wr_drive;
   logic                   wr_source;
   logic                   wr_strobe;
   logic                   wr_loads;

   // Software visible state.
   logic [EEFF_DRV_W-1:0]  drive_reg;
   logic                   source_reg;
   logic                   strobe_reg;
   logic [31:0]            rdata_reg;
   logic [31:0]            rd_value;
   logic                   hready_reg;
   logic                   hresp_reg;

   // Effective cell inputs.
   logic                   eff_data;
   logic                   eff_enable;
   logic                   eff_reset_n;
   logic                   eff_set_n;

   // Cell outputs and load tracking.
   logic                   plain_q;
   logic                   reset_q;
   logic                   set_q;
   logic [EEFF_NUM_CELLS-1:0] load_event;
   logic [LOAD_COUNT_W-1:0]   load_cnt [EEFF_NUM_CELLS];

   // A transfer is taken when selected, active and the bus is ready.
   assign addr_phase = i_hsel && i_htrans[EEFF_HTRANS_BUSY] && i_hready;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         wr_pend_reg <= 1'b0;
      end else begin
         wr_pend_reg <= addr_phase && i_hwrite;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         wr_addr_reg <= '0;
      end else if (addr_phase) begin
         wr_addr_reg <= i_haddr[EEFF_ADDR_W-1:0];
      end
   end

   // Write data is taken at the end of the data phase.
   assign wr_drive  = wr_pend_reg && (wr_addr_reg == EEFF_OFS_DRIVE);
   assign wr_source = wr_pend_reg && (wr_addr_reg == EEFF_OFS_SOURCE);
   assign wr_strobe = wr_pend_reg && (wr_addr_reg == EEFF_OFS_STROBE);
   assign wr_loads  = wr_pend_reg && (wr_addr_reg == EEFF_OFS_LOADS);

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         drive_reg <= EEFF_DRV_RESET;
      end else if (wr_drive) begin
         drive_reg <= i_hwdata[EEFF_DRV_W-1:0];
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         source_reg <= EEFF_SRC_RESET;
      end else if (wr_source) begin
         source_reg <= i_hwdata[EEFF_SRC_REG];
      end
   end

   // A strobe write gives one cycle of enable.
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= wr_strobe && i_hwdata[EEFF_STB_EN];
      end
   end

   // Cell inputs come from the pins or from the drive register.
   always_comb begin
      if (source_reg) begin
         eff_data    = drive_reg[EEFF_DRV_DATA];
         eff_enable  = drive_reg[EEFF_DRV_EN] | strobe_reg;
         eff_reset_n = drive_reg[EEFF_DRV_RSTN];
         eff_set_n   = drive_reg[EEFF_DRV_SETN];
      end else begin
         eff_data    = i_data_in;
         eff_enable  = i_enable_in | strobe_reg;
         eff_reset_n = i_reset_low_in;
         eff_set_n   = i_set_low_in;
      end
   end

   eeff_cell #(
      .VARIANT      (EEFF_VAR_PLAIN),
      .FORCE_TIMING (EEFF_TIMING_DEFAULT),
      .INIT_VALUE   (PLAIN_INIT)
   ) u_plain (
      .i_clock       (i_clock),
      .i_data        (eff_data),
      .i_enable      (eff_enable),
      .i_force_low_n (1'b1),
      .o_q           (plain_q)
   );

   eeff_cell #(
      .VARIANT      (EEFF_VAR_RESET),
      .FORCE_TIMING (RESET_TIMING),
      .INIT_VALUE   (RESET_INIT)
   ) u_reset (
      .i_clock       (i_clock),
      .i_data        (eff_data),
      .i_enable      (eff_enable),
      .i_force_low_n (eff_reset_n),
      .o_q           (reset_q)
   );

   eeff_cell #(
      .VARIANT      (EEFF_VAR_SET),
      .FORCE_TIMING (SET_TIMING),
      .INIT_VALUE   (SET_INIT)
   ) u_set (
      .i_clock       (i_clock),
      .i_data        (eff_data),
      .i_enable      (eff_enable),
      .i_force_low_n (eff_set_n),
      .o_q           (set_q)
   );

   assign o_plain_q = plain_q;
   assign o_reset_q = reset_q;
   assign o_set_q   = set_q;

   // A cell loads data on an edge with enable high and its force released.
   assign load_event[0] = eff_enable;
   assign load_event[1] = eff_enable && eff_reset_n;
   assign load_event[2] = eff_enable && eff_set_n;

   // Load counters wrap; a load in the clearing cycle is still counted.
   for (genvar c = 0; c < EEFF_NUM_CELLS; c++) begin : g_cnt
      always_ff @(posedge i_clock or posedge i_reset) begin
         if (i_reset) begin
            load_cnt[c] <= '0;
         end else if (wr_loads) begin
            load_cnt[c] <= LOAD_COUNT_W'(load_event[c]);
         end else if (load_event[c]) begin
            load_cnt[c] <= load_cnt[c] + LOAD_COUNT_W'(1);
         end
      end
   end

   // Read value for the address phase now on the bus.
   always_comb begin
      rd_value = '0;
      unique case (i_haddr[EEFF_ADDR_W-1:0])
         EEFF_OFS_DRIVE: begin
            rd_value[EEFF_DRV_W-1:0] = drive_reg;
         end
         EEFF_OFS_SOURCE: begin
            rd_value[EEFF_SRC_REG] = source_reg;
         end
         EEFF_OFS_STATUS: begin
            rd_value[EEFF_ST_Q_LSB]     = plain_q;
            rd_value[EEFF_ST_Q_LSB + 1] = reset_q;
            rd_value[EEFF_ST_Q_LSB + 2] = set_q;
            rd_value[EEFF_ST_DATA]      = eff_data;
            rd_value[EEFF_ST_EN]        = eff_enable;
            rd_value[EEFF_ST_RSTN]      = eff_reset_n;
            rd_value[EEFF_ST_SETN]      = eff_set_n;
         end
         EEFF_OFS_CONFIG: begin
            rd_value[EEFF_CFG_RST_ASYNC]    = RESET_ASYNC;
            rd_value[EEFF_CFG_SET_ASYNC]    = SET_ASYNC;
            rd_value[EEFF_CFG_INIT_LSB]     = PLAIN_INIT;
            rd_value[EEFF_CFG_INIT_LSB + 1] = RESET_INIT;
            rd_value[EEFF_CFG_INIT_LSB + 2] = SET_INIT;
         end
         EEFF_OFS_LOADS: begin
            rd_value[0 +: LOAD_COUNT_W] = load_cnt[0];
            rd_value[EEFF_LD_FIELD_W +: LOAD_COUNT_W] = load_cnt[1];
            rd_value[2 * EEFF_LD_FIELD_W +: LOAD_COUNT_W] = load_cnt[2];
         end
         default: begin
            rd_value = '0;
         end
      endcase
   end

   // Read data is captured at the address phase and stands for the data phase.
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         rdata_reg <= '0;
      end else if (addr_phase && !i_hwrite) begin
         rdata_reg <= rd_value;
      end else begin
         rdata_reg <= '0;
      end
   end

   // The slave never inserts wait states and always answers okay.
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         hready_reg <= 1'b1;
      end else begin
         hready_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         hresp_reg <= EEFF_HRESP_OKAY;
      end else begin
         hresp_reg <= EEFF_HRESP_OKAY;
      end
   end

   assign o_hrdata    = rdata_reg;
   assign o_hreadyout = hready_reg;
   assign o_hresp     = hresp_reg;

endmodule // eeff_top

// ---- eeff_pkg.sv ----
// Constants, types and option decoding shared by the enabled flop block.
package eeff_pkg;

   // Cell variants.
   typedef enum logic [1:0] {
      EEFF_VAR_PLAIN = 2'b00,
      EEFF_VAR_RESET = 2'b01,
      EEFF_VAR_SET   = 2'b10
   } eeff_variant_t;

   // Spellings of the force timing option.
   localparam string EEFF_TIMING_UNCLOCKED = "unclocked";
   localparam string EEFF_TIMING_UNLOCKED  = "unlocked";
   localparam string EEFF_TIMING_CLOCKED   = "clocked";
   localparam string EEFF_TIMING_DEFAULT   = EEFF_TIMING_UNCLOCKED;

   // Power-up values.
   localparam logic EEFF_INIT_PLAIN = 1'b0;
   localparam logic EEFF_INIT_RESET = 1'b0;
   localparam logic EEFF_INIT_SET   = 1'b1;

   // Bus geometry.
   localparam int          EEFF_DATA_W      = 32;
   localparam int          EEFF_ADDR_W      = 8;
   localparam int          EEFF_HTRANS_BUSY = 1;
   localparam logic        EEFF_HRESP_OKAY  = 1'b0;

   // Register offsets.
   localparam logic [7:0] EEFF_OFS_DRIVE  = 8'h00;
   localparam logic [7:0] EEFF_OFS_SOURCE = 8'h04;
   localparam logic [7:0] EEFF_OFS_STROBE = 8'h08;
   localparam logic [7:0] EEFF_OFS_STATUS = 8'h0c;
   localparam logic [7:0] EEFF_OFS_CONFIG = 8'h10;
   localparam logic [7:0] EEFF_OFS_LOADS  = 8'h14;

   // Drive register fields and reset value.
   localparam int         EEFF_DRV_DATA  = 0;
   localparam int         EEFF_DRV_EN    = 1;
   localparam int         EEFF_DRV_RSTN  = 2;
   localparam int         EEFF_DRV_SETN  = 3;
   localparam int         EEFF_DRV_W     = 4;
   localparam logic [3:0] EEFF_DRV_RESET = 4'hc;

   // Source and strobe fields.
   localparam int   EEFF_SRC_REG       = 0;
   localparam logic EEFF_SRC_RESET     = 1'b0;
   localparam int   EEFF_STB_EN        = 0;

   // Status fields.
   localparam int EEFF_ST_Q_LSB  = 0;
   localparam int EEFF_ST_DATA   = 3;
   localparam int EEFF_ST_EN     = 4;
   localparam int EEFF_ST_RSTN   = 5;
   localparam int EEFF_ST_SETN   = 6;

   // Config fields.
   localparam int EEFF_CFG_RST_ASYNC = 0;
   localparam int EEFF_CFG_SET_ASYNC = 1;
   localparam int EEFF_CFG_INIT_LSB  = 2;

   // Load counter fields.
   localparam int EEFF_LD_FIELD_W = 8;
   localparam int EEFF_NUM_CELLS  = 3;

   function automatic bit eeff_is_async(input string s);
      return (s == EEFF_TIMING_UNCLOCKED) || (s == EEFF_TIMING_UNLOCKED);
   endfunction

   function automatic bit eeff_timing_ok(input string s);
      return eeff_is_async(s) || (s == EEFF_TIMING_CLOCKED);
   endfunction

endpackage

// ---- eeff_cell.sv ----
// One rising edge flop with clock enable and optional active low reset or set.
`timescale 1ns/100ps
module eeff_cell #(
   parameter eeff_pkg::eeff_variant_t VARIANT      = eeff_pkg::EEFF_VAR_PLAIN,
   parameter string                   FORCE_TIMING = eeff_pkg::EEFF_TIMING_DEFAULT,
   parameter logic                    INIT_VALUE   = eeff_pkg::EEFF_INIT_PLAIN
) (
   input  wire logic i_clock,
   input  wire logic i_data,
   input  wire logic i_enable,
   input  wire logic i_force_low_n,
   output logic      o_q
);
   import eeff_pkg::*;

   localparam logic FORCE_VALUE = (VARIANT == EEFF_VAR_SET);
   localparam bit   ASYNC_FORCE = eeff_is_async(FORCE_TIMING);

   if (!eeff_timing_ok(FORCE_TIMING)) begin : g_bad_timing
      $error("Force timing option is not recognised.");
   end

   // The power-up value is loaded once only and no later reset reloads it.
   logic q_reg = INIT_VALUE;

   if (VARIANT == EEFF_VAR_PLAIN) begin : g_plain
      always_ff @(posedge i_clock) begin
         if (i_enable) begin
            q_reg <= i_data;
         end
      end
   end else if (ASYNC_FORCE) begin : g_async
      always_ff @(posedge i_clock or negedge i_force_low_n) begin
         if (!i_force_low_n) begin
            q_reg <= FORCE_VALUE;
         end else if (i_enable) begin
            q_reg <= i_data;
         end
      end
   end else begin : g_sync
      always_ff @(posedge i_clock) begin
         if (!i_force_low_n) begin
            q_reg <= FORCE_VALUE;
         end else if (i_enable) begin
            q_reg <= i_data;
         end
      end
   end

   assign o_q = q_reg;

endmodule // eeff_cell

// ---- eeff_checker.sv ----
// Concurrent checks on the ports of the enabled flop trio.
`timescale 1ns/100ps
module eeff_checker #(
   parameter string RESET_TIMING = eeff_pkg::EEFF_TIMING_DEFAULT,
   parameter string SET_TIMING   = eeff_pkg::EEFF_TIMING_DEFAULT
) (
   input wire logic        i_clock,
   input wire logic        i_reset,
   input wire logic        i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic        i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic        o_hreadyout,
   input wire logic        o_hresp,
   input wire logic        i_data_in,
   input wire logic        i_enable_in,
   input wire logic        i_reset_low_in,
   input wire logic        i_set_low_in,
   input wire logic        o_plain_q,
   input wire logic        o_reset_q,
   input wire logic        o_set_q
);
   import eeff_pkg::*;

   localparam bit RESET_ASYNC = eeff_is_async(RESET_TIMING);
   localparam bit SET_ASYNC   = eeff_is_async(SET_TIMING);

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   // The cells follow the pins only while neither the source register nor a strobe is in use.
   logic wr_taken;
   logic src_wr_reg;
   logic stb_wr_reg;
   logic src_reg;
   logic stb_reg;
   logic pin_mode;

   assign wr_taken = i_hsel && i_htrans[1] && i_hready && i_hwrite;
   assign pin_mode = !src_reg && !stb_reg;

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         src_wr_reg <= 1'b0;
         stb_wr_reg <= 1'b0;
      end else begin
         src_wr_reg <= wr_taken && (i_haddr[EEFF_ADDR_W-1:0] == EEFF_OFS_SOURCE);
         stb_wr_reg <= wr_taken && (i_haddr[EEFF_ADDR_W-1:0] == EEFF_OFS_STROBE);
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         src_reg <= 1'b0;
         stb_reg <= 1'b0;
      end else begin
         if (src_wr_reg) begin
            src_reg <= i_hwdata[EEFF_SRC_REG];
         end
         stb_reg <= stb_wr_reg && i_hwdata[EEFF_STB_EN];
      end
   end

   sequence reset_load_s;
      pin_mode && i_reset_low_in && i_enable_in ##1 pin_mode && i_reset_low_in;
   endsequence
   sequence reset_hold_s;
      pin_mode && i_reset_low_in && !i_enable_in ##1 pin_mode && i_reset_low_in;
   endsequence
   sequence set_load_s;
      pin_mode && i_set_low_in && i_enable_in ##1 pin_mode && i_set_low_in;
   endsequence
   sequence set_hold_s;
      pin_mode && i_set_low_in && !i_enable_in ##1 pin_mode && i_set_low_in;
   endsequence
   plain_load_a: assert property (pin_mode && i_enable_in |=> o_plain_q == $past(i_data_in))
      else $error("Plain cell missed a load.");
   plain_hold_a: assert property (pin_mode && !i_enable_in |=> $stable(o_plain_q))
      else $error("Plain cell changed while disabled.");
   reset_load_a: assert property (reset_load_s |-> o_reset_q == $past(i_data_in))
      else $error("Reset cell missed a load.");
   reset_hold_a: assert property (reset_hold_s |-> $stable(o_reset_q))
      else $error("Reset cell changed while disabled.");
   reset_clear_a: assert property (pin_mode && !i_reset_low_in |=> !o_reset_q)
      else $error("Reset cell not cleared at the edge.");
   reset_async_a: assert property (RESET_ASYNC && pin_mode && !i_reset_low_in |-> !o_reset_q)
      else $error("Reset cell not cleared at once.");
   set_force_a: assert property (SET_ASYNC && pin_mode && !i_set_low_in |-> o_set_q)
      else $error("Set cell not forced high.");
   set_edge_a: assert property (pin_mode && !i_set_low_in |=> o_set_q)
      else $error("Set cell not set at the edge.");
   set_load_a: assert property (set_load_s |-> o_set_q == $past(i_data_in))
      else $error("Set cell missed a load.");
   set_hold_a: assert property (set_hold_s |-> $stable(o_set_q))
      else $error("Set cell changed while disabled.");
   bus_okay_a: assert property (o_hreadyout && (o_hresp == 1'b0))
      else $error("Bus answer not ready and okay.");
   read_idle_a: assert property (!(i_hsel && i_htrans[1] && i_hready && !i_hwrite) |=> o_hrdata == 32'h0)
      else $error("Read data outside a read.");
endmodule // eeff_checker

bind eeff_top eeff_checker #(.RESET_TIMING(RESET_TIMING), .SET_TIMING(SET_TIMING)) chk_u (.i_clock(i_clock),
   .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
   .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .i_data_in(i_data_in), .i_enable_in(i_enable_in), .i_reset_low_in(i_reset_low_in),
   .i_set_low_in(i_set_low_in), .o_plain_q(o_plain_q), .o_reset_q(o_reset_q), .o_set_q(o_set_q));

// ---- eeff_fabric.sv ----
// Model of the user logic that drives the flop pins.
`timescale 1ns/100ps
module eeff_fabric (
   input  wire logic       i_clock,
   input  wire logic [3:0] i_cmd,
   output logic            o_data,
   output logic            o_enable,
   output logic            o_reset_low,
   output logic            o_set_low
);
   initial {o_set_low, o_reset_low, o_enable, o_data} = 4'hc;
   always @(posedge i_clock) begin
      {o_set_low, o_reset_low, o_enable, o_data} <= i_cmd;
   end
endmodule // eeff_fabric

// ---- enabled_edge_flop_set_reset_tb.sv ----
// Self-checking bench for the enabled flop trio.
`timescale 1ns/100ps
module enabled_edge_flop_set_reset_tb;
   import eeff_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0]  cmd = 4'hc;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hready, hresp, pin_d, pin_en, pin_rn, pin_sn, q_plain, q_reset, q_set;
   logic [31:0] hrdata2;
   logic        hready2, hresp2, q2_plain, q2_reset, q2_set;
   int          mismatches = 0;
   int          n_tests = 0;
   always #20 clock = ~clock;
   eeff_fabric fab_u (.i_clock(clock), .i_cmd(cmd), .o_data(pin_d), .o_enable(pin_en),
      .o_reset_low(pin_rn), .o_set_low(pin_sn));
   eeff_top #(.RESET_TIMING(EEFF_TIMING_CLOCKED), .SET_TIMING(EEFF_TIMING_UNLOCKED)) dut_u (
      .i_clock(clock), .i_reset(reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
      .o_hreadyout(hready), .o_hresp(hresp), .i_data_in(pin_d), .i_enable_in(pin_en),
      .i_reset_low_in(pin_rn), .i_set_low_in(pin_sn), .o_plain_q(q_plain), .o_reset_q(q_reset),
      .o_set_q(q_set));
   eeff_top #(.SET_TIMING(EEFF_TIMING_CLOCKED)) dut2_u (
      .i_clock(clock), .i_reset(reset), .i_hsel(1'b0), .i_haddr(32'h0), .i_htrans(2'h0),
      .i_hwrite(1'b0), .i_hsize(3'h2), .i_hwdata(32'h0), .i_hready(hready2), .o_hrdata(hrdata2),
      .o_hreadyout(hready2), .o_hresp(hresp2), .i_data_in(pin_d), .i_enable_in(pin_en),
      .i_reset_low_in(pin_rn), .i_set_low_in(pin_sn), .o_plain_q(q2_plain), .o_reset_q(q2_reset),
      .o_set_q(q2_set));
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clock);
      while (hready !== 1'b1) @(posedge clock);
      r = hrdata;
   endtask
   task automatic set_pins(input logic [3:0] v);
      @(negedge clock);
      cmd = v;
      @(posedge clock);
      #1;
   endtask
   task automatic step;
      @(posedge clock);
      #1;
   endtask
   task automatic wrap_up;
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      #1;
      check_bit(q_plain, 1'b0);
      check_bit(q_reset, 1'b0);
      check_bit(q_set, 1'b1);
      check_word({29'h0, q2_set, q2_reset, q2_plain}, 32'h4);
      $display("Test power-up done");
      set_pins(4'hf);
      step();
      check_word({29'h0, q_set, q_reset, q_plain}, 32'h7);
      set_pins(4'hc);
      step();
      check_word({29'h0, q_set, q_reset, q_plain}, 32'h7);
      $display("Test load and hold done");
      set_pins(4'h8);
      check_bit(q_reset, 1'b1);
      check_bit(q2_reset, 1'b0);
      step();
      check_bit(q_reset, 1'b0);
      check_bit(q_plain, 1'b1);
      $display("Test clocked reset done");
      set_pins(4'he);
      step();
      check_word({29'h0, q_set, q_reset, q_plain}, 32'h0);
      set_pins(4'h6);
      check_bit(q_set, 1'b1);
      check_bit(q2_set, 1'b0);
      step();
      check_bit(q_set, 1'b1);
      check_bit(q2_set, 1'b1);
      set_pins(4'hc);
      $display("Test unclocked set done");
      ahb(1'b0, EEFF_OFS_CONFIG, 32'h0, rd);
      check_word(rd, 32'h12);
      ahb(1'b0, EEFF_OFS_DRIVE, 32'h0, rd);
      check_word(rd, 32'hc);
      ahb(1'b1, EEFF_OFS_DRIVE, 32'h5, rd);
      ahb(1'b0, EEFF_OFS_DRIVE, 32'h0, rd);
      check_word(rd, 32'h5);
      ahb(1'b0, 8'h20, 32'h0, rd);
      check_word(rd, 32'h0);
      ahb(1'b1, EEFF_OFS_LOADS, 32'h0, rd);
      set_pins(4'hf);
      repeat (2) @(posedge clock);
      set_pins(4'hc);
      ahb(1'b0, EEFF_OFS_LOADS, 32'h0, rd);
      check_word(rd, 32'h00030303);
      ahb(1'b1, EEFF_OFS_STROBE, 32'h1, rd);
      step();
      check_word({29'h0, q_set, q_reset, q_plain}, 32'h0);
      ahb(1'b1, EEFF_OFS_DRIVE, 32'hf, rd);
      ahb(1'b1, EEFF_OFS_SOURCE, 32'h1, rd);
      ahb(1'b0, EEFF_OFS_STATUS, 32'h0, rd);
      check_word(rd, 32'h7f);
      ahb(1'b1, EEFF_OFS_SOURCE, 32'h0, rd);
      $display("Test registers done");
      wrap_up();
   end
endmodule // enabled_edge_flop_set_reset_tb
